// ==== design/btgx_exec.sv ====
// Execution unit for bit invert and bit test-skip instructions
// Functional notes
// RULE1: Invert opcode flips only the indexed bit; status flags untouched.
// RULE2: Access bit zero resolves the file address inside the access bank.
// RULE3: Access bit one forms address from bank select register and file.
// RULE4: Extended set, access zero, address up to 5Fh: indexed offset.
// RULE5: One word, one cycle: decode, read file, process, write back.
`timescale 1ns/1ps
module btgx_exec
   import btgx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [15:0] instrWord,
   input wire logic instrValid,
   input wire logic [3:0] bankSelectReg,
   input wire logic extSetEn,
   input wire logic [11:0] indexBase,
   input wire logic [7:0] memRdData,
   output btgx_mem_req_t memReq,
   output logic skipNext,
   output logic statusWrEn,
   output btgx_phase_t phase
);
   btgx_phase_t phase_reg, phase_next;
   btgx_dec_t dec_reg, dec_next;
   logic [11:0] addr_reg, addr_next;
   logic [7:0] data_reg, data_next;
   logic skip_reg, skip_next;
   logic active_reg, active_next;
   btgx_dec_t decNow;
   logic [11:0] addrNow;

   // Field split of the incoming word
   always_comb begin
      decNow.invert = instrValid &&
         instrWord[OPC_MSB:OPC_LSB] == OPC_INVERT;
      decNow.testClr = instrValid &&
         instrWord[OPC_MSB:OPC_LSB] == OPC_TEST_CLR;
      decNow.testSet = instrValid &&
         instrWord[OPC_MSB:OPC_LSB] == OPC_TEST_SET;
      decNow.bitIdx = instrWord[BIT_MSB:BIT_LSB];
      decNow.accSel = instrWord[ACC_POS];
      decNow.fileAddr = instrWord[FILE_MSB:0];
   end

   // Address resolution; indexed mode wins over plain access bank
   always_comb begin
      if (dec_reg.accSel) begin
         addrNow = {bankSelectReg, dec_reg.fileAddr}; // RULE3
      end else if (extSetEn && dec_reg.fileAddr <= INDEX_LIMIT) begin
         addrNow = indexBase + {4'h0, dec_reg.fileAddr}; // RULE4
      end else if (dec_reg.fileAddr < ACCESS_SPLIT) begin
         addrNow = {BANK_RESET, dec_reg.fileAddr}; // RULE2
      end else begin
         addrNow = {ACCESS_HI_BANK, dec_reg.fileAddr}; // RULE2
      end
   end

   // Phase sequencer and datapath next state
   always_comb begin
      phase_next = phase_reg;
      dec_next = dec_reg;
      addr_next = addr_reg;
      data_next = data_reg;
      skip_next = skip_reg;
      active_next = active_reg;
      case (phase_reg)
         BTGX_Q1: begin
            dec_next = decNow; // RULE5
            active_next = decNow.invert | decNow.testClr | decNow.testSet;
            skip_next = 1'b0;
            phase_next = BTGX_Q2;
         end
         BTGX_Q2: begin
            addr_next = addrNow; // RULE5
            phase_next = BTGX_Q3;
         end
         BTGX_Q3: begin
            // Only the selected bit changes
            data_next = memRdData ^ (8'h01 << dec_reg.bitIdx); // RULE1
            skip_next = active_reg &&
               ((dec_reg.testClr && !memRdData[dec_reg.bitIdx]) ||
                (dec_reg.testSet && memRdData[dec_reg.bitIdx]));
            phase_next = BTGX_Q4;
         end
         BTGX_Q4: begin
            phase_next = BTGX_Q1;
         end
         default: begin
            phase_next = BTGX_Q1;
         end
      endcase
   end

   // State registers, frozen while clock enable is low
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         phase_reg <= BTGX_Q1;
         dec_reg <= '0;
         addr_reg <= ADDR_RESET;
         data_reg <= DATA_RESET;
         skip_reg <= 1'b0;
         active_reg <= 1'b0;
      end else if (clkEn) begin
         phase_reg <= phase_next;
         dec_reg <= dec_next;
         addr_reg <= addr_next;
         data_reg <= data_next;
         skip_reg <= skip_next;
         active_reg <= active_next;
      end
   end

   // Read in Q3 so data is captured there; write only in Q4
   // One assignment for the whole struct keeps a single driver
   assign memReq = '{
      rdEn: active_reg && phase_reg == BTGX_Q3,
      wrEn: active_reg && dec_reg.invert && phase_reg == BTGX_Q4, // RULE5
      addr: addr_reg,
      wrData: data_reg
   };
   assign statusWrEn = 1'b0; // RULE1
   // Skip request held for the fetch pipeline during Q4
   assign skipNext = skip_reg && phase_reg == BTGX_Q4;
   assign phase = phase_reg;

   // Assertions
   sequence invertStart_s;
      clkEn && phase_reg == BTGX_Q1 && decNow.invert;
   endsequence

   invert_write_a: assert property (@(posedge ref_clk) disable iff (srst)
      invertStart_s ##1 clkEn[*3] |-> memReq.wrEn) // RULE5
      else $error("invert did not write in Q4");

   invert_data_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.wrEn |-> $countones(memReq.wrData ^
      $past(memRdData)) == 1) // RULE1
      else $error("write data differs in other than one bit");

   no_status_a: assert property (@(posedge ref_clk) disable iff (srst)
      !statusWrEn) // RULE1
      else $error("status written by bit op");

   bank_addr_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.rdEn && dec_reg.accSel |->
      memReq.addr[7:0] == dec_reg.fileAddr) // RULE3
      else $error("banked address low byte wrong");

   access_low_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.rdEn && !dec_reg.accSel && !extSetEn &&
      dec_reg.fileAddr < ACCESS_SPLIT |-> memReq.addr[11:8] == 4'h0)
      // RULE2
      else $error("access bank low half wrong");

   access_high_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.rdEn && !dec_reg.accSel &&
      dec_reg.fileAddr > INDEX_LIMIT |-> memReq.addr[11:8] == 4'hF)
      // RULE2
      else $error("access bank high half wrong");

   phase_cycle_a: assert property (@(posedge ref_clk) disable iff (srst)
      clkEn && phase_reg == BTGX_Q4 |=> phase_reg == BTGX_Q1) // RULE5
      else $error("phase did not wrap");

   write_only_q4_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.wrEn |-> phase_reg == BTGX_Q4 && $past(memReq.rdEn,1)
      || !$past(clkEn)) // RULE5
      else $error("write outside Q4");

   // Non-decoded words must stay off the memory
   sequence refuseStart_s;
      clkEn && phase_reg == BTGX_Q1 &&
      !(decNow.invert || decNow.testClr || decNow.testSet);
   endsequence

   refused_quiet_a: assert property (@(posedge ref_clk) disable iff (srst)
      refuseStart_s ##1 clkEn[*3] |-> !memReq.wrEn && !skipNext) // RULE5
      else $error("refused word caused traffic");

   // Low clock enable freezes the sequencer
   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
      !clkEn |=> $stable(phase_reg)) // RULE5
      else $error("phase moved while frozen");

   // Skip is only offered by test ops in Q4
   skip_q4_a: assert property (@(posedge ref_clk) disable iff (srst)
      skipNext |-> phase_reg == BTGX_Q4 &&
      (dec_reg.testClr || dec_reg.testSet)) // RULE5
      else $error("skip outside a test op");

   // Test ops read only; the write belongs to invert
   test_no_write_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.wrEn |-> dec_reg.invert) // RULE1
      else $error("write from a test op");

   // Banked upper nibble comes from the bank select input
   bank_high_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.rdEn && dec_reg.accSel |->
      memReq.addr[11:8] == bankSelectReg) // RULE3
      else $error("banked address high nibble wrong");

   // Indexed offset adds the file field to the base
   index_addr_a: assert property (@(posedge ref_clk) disable iff (srst)
      memReq.rdEn && !dec_reg.accSel && extSetEn &&
      dec_reg.fileAddr <= INDEX_LIMIT |->
      memReq.addr == indexBase + {4'h0, dec_reg.fileAddr}) // RULE4
      else $error("indexed address wrong");
endmodule

// ==== inc/btgx_pkg.sv ====
// Package for the bit-invert and test-skip execution block
package btgx_pkg;
   // Opcode high nibbles
   localparam logic [3:0] OPC_INVERT = 4'h7;
   localparam logic [3:0] OPC_TEST_CLR = 4'hB;
   localparam logic [3:0] OPC_TEST_SET = 4'hA;
   // Field positions inside the 16-bit instruction word
   localparam int OPC_MSB = 15;
   localparam int OPC_LSB = 12;
   localparam int BIT_MSB = 11;
   localparam int BIT_LSB = 9;
   localparam int ACC_POS = 8;
   localparam int FILE_MSB = 7;
   // Access bank split and indexed-offset limit
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [11:0] ADDR_RESET = 12'h000;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // Four-phase instruction cycle, Gray coded
   typedef enum logic [1:0] {
      BTGX_Q1 = 2'b00,
      BTGX_Q2 = 2'b01,
      BTGX_Q3 = 2'b11,
      BTGX_Q4 = 2'b10
   } btgx_phase_t;

   // Memory request toward the data memory
   typedef struct packed {
      logic rdEn;
      logic wrEn;
      logic [11:0] addr;
      logic [7:0] wrData;
   } btgx_mem_req_t;

   // Decoded operand fields
   typedef struct packed {
      logic invert;
      logic testClr;
      logic testSet;
      logic [2:0] bitIdx;
      logic accSel;
      logic [7:0] fileAddr;
   } btgx_dec_t;
endpackage

// ==== test/btgx_exec_tb_top.sv ====
// Self-checking bench for the bit-invert and test-skip unit
`timescale 1ns/1ps
module btgx_exec_tb_top;
   import btgx_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic clkEn = 1'b1;
   logic [15:0] instrWord = 16'h0000;
   logic instrValid = 1'b0;
   logic [3:0] bankSelectReg = 4'h0;
   logic extSetEn = 1'b0;
   logic [11:0] indexBase = 12'h100;
   logic [7:0] memRdData = 8'h00;
   btgx_mem_req_t memReq;
   logic skipNext;
   logic statusWrEn;
   btgx_phase_t phase;
   int nFail = 0;
   int nChecks = 0;
`define CHK(n, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
   $display("wrong value %s exp %h got %h", n, e, g); end end

   // 250 MHz core clock
   always #2 ref_clk = ~ref_clk;

   btgx_exec i_dut (.ref_clk(ref_clk), .srst(srst), .clkEn(clkEn),
      .instrWord(instrWord), .instrValid(instrValid),
      .bankSelectReg(bankSelectReg), .extSetEn(extSetEn),
      .indexBase(indexBase), .memRdData(memRdData), .memReq(memReq),
      .skipNext(skipNext), .statusWrEn(statusWrEn), .phase(phase));

   task automatic final_report();
      $display("checks %0d mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One instruction word through all four phases, judged mid-phase
   task automatic exec(input logic [15:0] w, input logic [7:0] rd,
         input logic [11:0] a, input logic sk);
      int i;
      logic inv;
      logic act;
      inv = (w[15:12] == OPC_INVERT);
      act = inv || w[15:12] == OPC_TEST_CLR || w[15:12] == OPC_TEST_SET;
      i = 0;
      // Bounded wait for Q4 so the word lands exactly in Q1
      do begin
         @(negedge ref_clk);
         i++;
      end while (phase !== BTGX_Q4 && i < 8);
      if (i >= 8) begin
         nFail++;
         final_report();
      end
      @(posedge ref_clk);
      instrWord <= w;
      instrValid <= 1'b1;
      memRdData <= rd;
      @(posedge ref_clk);
      instrValid <= 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK("rdEn", act, memReq.rdEn)
      if (act)
         `CHK("addr", a, memReq.addr)
      @(negedge ref_clk);
      `CHK("phase", BTGX_Q4, phase)
      `CHK("wrEn", inv, memReq.wrEn)
      if (inv)
         `CHK("wrData", rd ^ (8'h01 << w[11:9]), memReq.wrData)
      `CHK("skipNext", sk, skipNext)
      `CHK("statusWrEn", 1'b0, statusWrEn)
   endtask

   // Access bank, both halves, bit indices 4 and 7
   task automatic t_access();
      exec({OPC_INVERT, 3'h4, 1'h0, 8'h82}, 8'h75, 12'hF82, 1'b0);
      exec({OPC_INVERT, 3'h7, 1'h0, 8'h10}, 8'h00, 12'h010, 1'b0);
   endtask

   // Skip tails must never write memory
   task automatic t_skip();
      exec({OPC_TEST_CLR, 3'h1, 1'h0, 8'h70}, 8'hFD, 12'hF70, 1'b1);
      exec({OPC_TEST_CLR, 3'h1, 1'h0, 8'h70}, 8'h02, 12'hF70, 1'b0);
      exec({OPC_TEST_SET, 3'h1, 1'h0, 8'h70}, 8'hFD, 12'hF70, 1'b0);
      exec({OPC_TEST_SET, 3'h1, 1'h0, 8'h70}, 8'h02, 12'hF70, 1'b1);
   endtask

   // Banked access wins even with the extended set on
   task automatic t_banked();
      @(posedge ref_clk);
      bankSelectReg <= 4'h5;
      extSetEn <= 1'b1;
      exec({OPC_INVERT, 3'h0, 1'h1, 8'h20}, 8'hFF, 12'h520, 1'b0);
   endtask

   // Indexed offset ends at 5Fh; 60h falls back to the access bank
   task automatic t_indexed();
      @(posedge ref_clk);
      extSetEn <= 1'b1;
      exec({OPC_INVERT, 3'h2, 1'h0, 8'h5F}, 8'h0F, 12'h15F, 1'b0);
      exec({OPC_INVERT, 3'h2, 1'h0, 8'h60}, 8'h0F, 12'hF60, 1'b0);
   endtask

   // Clock enable low in Q3 must hold the read and delay the write
   task automatic t_freeze();
      int i;
      i = 0;
      do begin
         @(negedge ref_clk);
         i++;
      end while (phase !== BTGX_Q4 && i < 8);
      if (i >= 8) begin
         nFail++;
         final_report();
      end
      @(posedge ref_clk);
      extSetEn <= 1'b0;
      instrWord <= {OPC_INVERT, 3'h3, 1'h0, 8'h90};
      instrValid <= 1'b1;
      memRdData <= 8'h00;
      @(posedge ref_clk);
      instrValid <= 1'b0;
      @(posedge ref_clk);
      clkEn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("frozen phase", BTGX_Q3, phase)
      `CHK("frozen rdEn", 1'b1, memReq.rdEn)
      `CHK("frozen addr", 12'hF90, memReq.addr)
      @(posedge ref_clk);
      clkEn <= 1'b1;
      @(posedge ref_clk);
      @(negedge ref_clk);
      `CHK("thawed phase", BTGX_Q4, phase)
      `CHK("thawed wrEn", 1'b1, memReq.wrEn)
      `CHK("thawed wrData", 8'h08, memReq.wrData)
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      srst <= 1'b0;
      t_access();
      t_skip();
      exec(16'h0F70, 8'h55, 12'h000, 1'b0);
      t_banked();
      t_indexed();
      t_freeze();
      final_report();
   end
endmodule
